// ### core/mcm_ctrl.sv
/*
  motor current monitor control: state machine, lamps, sample tick,
  overlapped frame buffer, spectrum feature pick, serial transmit path.
  assumes switch, fault, flow and serial pins are asynchronous; converter,
  spectrum and classifier inputs come from logic on mclk_i.
*/
// Overview of operation
// - a 2 kHz tick captures one phase-current conversion each period
// - each captured sample is a 12-bit converter result
// - samples gather into 512-sample frames; a full count completes a frame
// - frames after the first reuse the previous frame's last 64 samples
// - spectrum magnitudes become dBFS with 4095 counts as 0 dB
// - pick the largest of bins 1 to 254 plus 8 bins each side
// - two class probabilities come in; abnormal one is the abnormality
// - power-up enters inactive with motor drive disabled
// - inactive moves to active when the run switch is on
// - an error in inactive goes straight to the error state
// - active lights active lamp, enables drive, inference and transfer
// - active takes the speed setpoint from the potentiometer
// - any error in active goes to the error state
// - overcurrent or other fault lights the error lamp and enters error
// - error leaves only by reset or clear switch going on to off
// - serial channel sends pc data; dma fills transmit register on request
// - flow input raises an interrupt on both edges
// - an output pin drives the inverse of the flow input level
`timescale 1ns/1ps
`include "mcm_map.svh"
module mcm_ctrl #(
  parameter int TICK_CYC = `MCM_CLK_HZ / `MCM_TICK_HZ,
  parameter int NBIN     = 256
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        run_switch_i,
  input  wire logic        error_clear_switch_i,
  input  wire logic        overcurrent_i,
  input  wire logic        fault_i,
  input  wire logic [11:0] speed_potentiometer_i,
  input  wire logic [11:0] current_converter_i,
  input  wire logic        spec_valid_i,
  input  wire logic [15:0] spec_mag_i,
  input  wire logic        spec_last_i,
  input  wire logic        cls_valid_i,
  input  wire logic [15:0] cls_prob_normal_i,
  input  wire logic [15:0] cls_prob_abnormal_i,
  input  wire logic        flow_edge_interrupt_i,
  input  wire logic        pc_sclk_i,
  input  wire logic        pc_csn_i,
  output logic [1:0]       state_o,
  output logic             motor_enable_o,
  output logic             active_lamp_o,
  output logic             error_lamp_o,
  output logic [11:0]      speed_setpoint_o,
  output logic             sample_tick_o,
  output logic             frame_ready_o,
  output logic [8:0]       frame_base_o,
  output logic             feat_valid_o,
  output logic [7:0]       feat_bin_o,
  output logic [15:0]      feat_db_o,
  output logic             feat_last_o,
  output logic [15:0]      abnormality_o,
  output logic             flow_irq_o,
  output logic             inverted_flow_output_o,
  output logic             pc_miso_o,
  output logic             pc_miso_oen_o
);
  localparam int TW = $clog2(TICK_CYC);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (TICK_CYC < 2 || NBIN != 256) begin : g_chk
    $error("mcm_ctrl: tick count below 2 or bin count not 256");
  end

  // pin index in the synchroniser vector
  localparam int P_RUN = 0;
  localparam int P_CLR = 1;
  localparam int P_OC  = 2;
  localparam int P_FLT = 3;
  localparam int P_SCK = 4;
  localparam int P_CSN = 5;
  localparam int P_FLW = 6;
  localparam int NPIN  = 7;
  // select idles high; its stages reset there so reset is no false select
  localparam logic [NPIN-1:0] PIN_IDLE = 7'h20;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m_q;
  logic [NPIN-1:0] pin_s_q;
  logic [NPIN-1:0] pin_p_q;

  assign pin_raw = {flow_edge_interrupt_i, pc_csn_i, pc_sclk_i, fault_i,
                    overcurrent_i, error_clear_switch_i, run_switch_i};

  // two stages per pin, then a delayed copy for edge detection
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
        pin_m_q[g] <= PIN_IDLE[g];
        pin_s_q[g] <= PIN_IDLE[g];
        pin_p_q[g] <= PIN_IDLE[g];
      end else begin
        pin_m_q[g] <= pin_raw[g];
        pin_s_q[g] <= pin_m_q[g];
        pin_p_q[g] <= pin_s_q[g];
      end
    end
  end

  // ************************************************************
  // system state machine
  // ************************************************************
  mcm_pkg::mcm_state_e st_q;
  mcm_pkg::mcm_state_e st_d;
  logic                err_now;
  logic                clr_fall;
  logic                active;

  assign err_now  = pin_s_q[P_OC] | pin_s_q[P_FLT];
  assign clr_fall = pin_p_q[P_CLR] & ~pin_s_q[P_CLR];
  assign active   = (st_q == mcm_pkg::mcm_active);

  // next state; a fault still present beats a clear
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      mcm_pkg::mcm_inactive: begin
        if (err_now) begin
          st_d = mcm_pkg::mcm_error;
        end else if (pin_s_q[P_RUN]) begin
          st_d = mcm_pkg::mcm_active;
        end
      end
      mcm_pkg::mcm_active: begin
        if (err_now) begin
          st_d = mcm_pkg::mcm_error;
        end else if (!pin_s_q[P_RUN]) begin
          st_d = mcm_pkg::mcm_inactive;
        end
      end
      mcm_pkg::mcm_error: begin
        if (clr_fall && !err_now) begin
          st_d = mcm_pkg::mcm_inactive;
        end
      end
      default: st_d = mcm_pkg::mcm_inactive;
    endcase
  end

  // state register, inactive after reset
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st_q <= mcm_pkg::mcm_inactive;
    end else begin
      st_q <= st_d;
    end
  end

  // lamps, drive enable and setpoint
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      active_lamp_o    <= 1'b0;
      error_lamp_o     <= 1'b0;
      motor_enable_o   <= 1'b0;
      speed_setpoint_o <= 12'h000;
    end else begin
      active_lamp_o    <= (st_d == mcm_pkg::mcm_active);
      error_lamp_o     <= (st_d == mcm_pkg::mcm_error);
      motor_enable_o   <= (st_d == mcm_pkg::mcm_active);
      speed_setpoint_o <= (st_d == mcm_pkg::mcm_active) ?
                          speed_potentiometer_i : 12'h000;
    end
  end

  assign state_o = st_q;

  // ************************************************************
  // sample tick and capture
  // ************************************************************
  logic [TW-1:0] tick_cnt_q;
  logic          tick;
  logic [11:0]   smp_q;
  logic          smp_new_q;

  assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));

  // tick divider, free running
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tick_cnt_q    <= '0;
      sample_tick_o <= 1'b0;
    end else begin
      tick_cnt_q    <= tick ? '0 : tick_cnt_q + 1'b1;
      sample_tick_o <= tick;
    end
  end

  // one 12-bit conversion taken per tick
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      smp_q     <= 12'h000;
      smp_new_q <= 1'b0;
    end else begin
      smp_new_q <= tick;
      if (tick) begin
        smp_q <= current_converter_i;
      end
    end
  end

  // ************************************************************
  // overlapped frame buffer
  // ************************************************************
  logic [11:0] frm_mem_q [512];
  logic [8:0]  wr_ptr_q;
  logic [9:0]  need_q;
  logic        frm_wr;
  logic        frm_done;

  assign frm_wr   = smp_new_q && active;
  assign frm_done = frm_wr && (need_q == 10'd1);

  // sample storage, circular over one frame length
  always_ff @(posedge mclk_i) begin
    if (frm_wr) begin
      frm_mem_q[wr_ptr_q] <= smp_q;
    end
  end

  // fill accounting; a full frame first, then only the fresh part
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !active) begin
      wr_ptr_q <= 9'h000;
      need_q   <= `MCM_FRAME_LEN;
    end else if (frm_wr) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
      need_q   <= frm_done ? (`MCM_FRAME_LEN - `MCM_OVERLAP)
                           : need_q - 1'b1;
    end
  end

  // frame hand-off: oldest sample sits just after the last write
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      frame_ready_o <= 1'b0;
      frame_base_o  <= 9'h000;
    end else begin
      frame_ready_o <= frm_done;
      if (frm_done) begin
        frame_base_o <= wr_ptr_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // spectrum to dBFS and peak feature pick
  // ************************************************************
  // log2 in q4 from the leading one, scaled to 1/16 dB below full scale
  function automatic logic signed [15:0] mcm_dbfs(input logic [15:0] m);
    logic [3:0]         k;
    logic [15:0]        n;
    logic signed [19:0] p;
    k = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        k = 4'(i);
      end
    end
    n = m << (4'hf - k);
    p = (20'(signed'({1'b0, k, n[14:11]})) - 20'(`MCM_FS_LOG2Q4))
        * `MCM_DB_PER_OCT;
    return (p > 20'sd0) ? 16'sh0000 : 16'(p >>> 6);
  endfunction

  logic signed [15:0] spec_mem_q [256];
  logic [7:0]         sbin_q;
  logic [7:0]         pk_bin_q;
  logic signed [15:0] pk_db_q;
  logic               emit_q;
  logic [7:0]         ebin_q;
  logic [7:0]         ehi_q;
  logic signed [15:0] in_db;

  assign in_db = mcm_dbfs(spec_mag_i);

  // store bins and track the peak, bin 0 left out
  always_ff @(posedge mclk_i) begin
    if (spec_valid_i) begin
      spec_mem_q[sbin_q] <= in_db;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sbin_q   <= 8'h00;
      pk_bin_q <= 8'h01;
      pk_db_q  <= 16'sh8000;
    end else if (spec_valid_i) begin
      sbin_q <= spec_last_i ? 8'h00 : sbin_q + 1'b1;
      if (sbin_q == 8'h00) begin
        pk_db_q <= 16'sh8000;
      end else if (in_db > pk_db_q) begin
        pk_db_q  <= in_db;
        pk_bin_q <= sbin_q;
      end
    end
  end

  // window of peak minus 8 to peak plus 8, clipped at the ends
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      emit_q       <= 1'b0;
      ebin_q       <= 8'h00;
      ehi_q        <= 8'h00;
      feat_valid_o <= 1'b0;
      feat_bin_o   <= 8'h00;
      feat_db_o    <= 16'h0000;
      feat_last_o  <= 1'b0;
    end else begin
      feat_valid_o <= emit_q;
      feat_last_o  <= emit_q && (ebin_q == ehi_q);
      if (emit_q) begin
        feat_bin_o <= ebin_q;
        feat_db_o  <= spec_mem_q[ebin_q];
        ebin_q     <= ebin_q + 1'b1;
        emit_q     <= (ebin_q != ehi_q);
      end else if (spec_valid_i && spec_last_i) begin
        emit_q <= 1'b1;
        ebin_q <= (pk_bin_q < `MCM_FEAT_SIDE) ? 8'h00 : pk_bin_q - `MCM_FEAT_SIDE;
        ehi_q  <= (pk_bin_q > 8'hff - `MCM_FEAT_SIDE) ? 8'hff
                                                     : pk_bin_q + `MCM_FEAT_SIDE;
      end
    end
  end

  // ************************************************************
  // abnormality report
  // ************************************************************
  logic abn_pend_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      abnormality_o <= 16'h0000;
    end else if (cls_valid_i && active) begin
      abnormality_o <= cls_prob_abnormal_i;
    end
  end

  // ************************************************************
  // transmit feed: frame readout and abnormality into the fifo
  // ************************************************************
  logic        rd_busy_q;
  logic [9:0]  rd_cnt_q;
  logic [8:0]  rd_ptr_q;
  logic        ff_in_valid;
  logic        ff_in_ready;
  logic [15:0] ff_in_data;
  logic        ff_out_valid;
  logic        ff_out_ready;
  logic [15:0] ff_out_data;
  logic        rd_push;

  assign ff_in_valid = rd_busy_q | abn_pend_q;
  assign ff_in_data  = rd_busy_q ? {`MCM_TAG_SAMPLE, frm_mem_q[rd_ptr_q]}
                                 : {`MCM_TAG_ABN, abnormality_o[15:4]};
  assign rd_push     = rd_busy_q && ff_in_ready;

  // readout walks one frame, stalled by fifo back-pressure
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !active) begin
      rd_busy_q <= 1'b0;
      rd_cnt_q  <= 10'h000;
      rd_ptr_q  <= 9'h000;
    end else if (frame_ready_o && !rd_busy_q) begin
      rd_busy_q <= 1'b1;
      rd_cnt_q  <= `MCM_FRAME_LEN;
      rd_ptr_q  <= frame_base_o;
    end else if (rd_push) begin
      rd_ptr_q  <= rd_ptr_q + 1'b1;
      rd_cnt_q  <= rd_cnt_q - 1'b1;
      rd_busy_q <= (rd_cnt_q != 10'd1);
    end
  end

  // pending abnormality word; a new result beats the push clear
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !active) begin
      abn_pend_q <= 1'b0;
    end else if (cls_valid_i) begin
      abn_pend_q <= 1'b1;
    end else if (!rd_busy_q && ff_in_ready) begin
      abn_pend_q <= 1'b0;
    end
  end

  mcm_fifo #(
    .W (16),
    .D (`MCM_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (ff_in_valid),
    .in_ready_o  (ff_in_ready),
    .in_data_i   (ff_in_data),
    .out_valid_o (ff_out_valid),
    .out_ready_i (ff_out_ready),
    .out_data_o  (ff_out_data)
  );

  // ************************************************************
  // transmit data register and dma move
  // ************************************************************
  logic [15:0] tdr_q;
  logic        tdr_full_q;
  logic        tx_load;

  // request while empty; held while the pc raises flow hold
  assign ff_out_ready = !tdr_full_q && active && !pin_s_q[P_FLW];

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tdr_q      <= 16'h0000;
      tdr_full_q <= 1'b0;
    end else if (ff_out_valid && ff_out_ready) begin
      tdr_q      <= ff_out_data;
      tdr_full_q <= 1'b1;
    end else if (tx_load) begin
      tdr_full_q <= 1'b0;
    end
  end

  // ************************************************************
  // serial shifter, clock and select sampled from the pc
  // ************************************************************
  logic [15:0] shf_q;
  logic [4:0]  bit_q;
  logic        sck_fall;
  logic        sel;

  assign sel      = !pin_s_q[P_CSN];
  assign sck_fall = pin_p_q[P_SCK] && !pin_s_q[P_SCK];
  assign tx_load  = sel && (bit_q == 5'd0);

  // msb first, next bit presented after each falling edge
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !sel) begin
      shf_q <= 16'h0000;
      bit_q <= 5'd0;
    end else if (tx_load) begin
      shf_q <= tdr_full_q ? tdr_q : 16'h0000;
      bit_q <= `MCM_SER_BITS;
    end else if (sck_fall) begin
      shf_q <= {shf_q[14:0], 1'b0};
      bit_q <= bit_q - 1'b1;
    end
  end

  assign pc_miso_o     = shf_q[15];
  assign pc_miso_oen_o = !sel;

  // ************************************************************
  // flow line: both-edge interrupt and inverted mirror
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      flow_irq_o             <= 1'b0;
      inverted_flow_output_o <= 1'b1;
    end else begin
      flow_irq_o             <= pin_s_q[P_FLW] ^ pin_p_q[P_FLW];
      inverted_flow_output_o <= !pin_s_q[P_FLW];
    end
  end
endmodule

// ### core/mcm_map.svh
/*
  constants of the motor current monitor: timing, frame layout,
  spectrum scaling and serial word tags.
  assumes a single inclusion point per compilation unit.
*/
`ifndef MCM_MAP_SVH
`define MCM_MAP_SVH

// ************************************************************
// timing
// ************************************************************
`define MCM_CLK_HZ      200000000
`define MCM_TICK_HZ     2000

// ************************************************************
// sample and frame layout
// ************************************************************
`define MCM_SAMPLE_W    12
`define MCM_FRAME_LEN   10'd512
`define MCM_OVERLAP     10'd64

// ************************************************************
// spectrum scaling and feature window
// ************************************************************
`define MCM_FS_LOG2Q4   9'sd191   // q4 log2 of 4095 counts, the 0 dB point
`define MCM_DB_PER_OCT  20'sd385
`define MCM_FEAT_SIDE   8'd8

// ************************************************************
// serial word tags and fifo
// ************************************************************
`define MCM_TAG_SAMPLE  4'h1
`define MCM_TAG_ABN     4'ha
`define MCM_SER_BITS    5'd16
`define MCM_FIFO_DEPTH  16

`endif

// ### core/mcm_pkg.sv
/*
  types shared by the motor current monitor files.
  assumes nothing beyond a SystemVerilog compiler.
*/
package mcm_pkg;

  // ************************************************************
  // controller states, gray coded along inactive-active-error
  // ************************************************************
  typedef enum logic [1:0] {
    mcm_inactive = 2'b00,
    mcm_active   = 2'b01,
    mcm_error    = 2'b11
  } mcm_state_e;

endpackage

// ### core/mcm_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module mcm_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  // ************************************************************
  // elaboration check
  // ************************************************************
  if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin : g_chk
    $error("mcm_fifo: depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         push;
  logic         pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid_o = (wp_q != rp_q);
  assign out_data_o  = mem_q[rp_q[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // storage write
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule

// ### sim/mcm_ctrl_checker.sv
/* port assertions for the motor current monitor control.
   assumes it is bound inside mcm_ctrl and sees its ports by name. */
`timescale 1ns/1ps
module mcm_ctrl_checker #(
  parameter int TICK_CYC = 20
) (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        error_clear_switch_i,
  input wire logic        overcurrent_i,
  input wire logic        fault_i,
  input wire logic        flow_edge_interrupt_i,
  input wire logic [1:0]  state_o,
  input wire logic        motor_enable_o,
  input wire logic        active_lamp_o,
  input wire logic        error_lamp_o,
  input wire logic [11:0] speed_setpoint_o,
  input wire logic        sample_tick_o,
  input wire logic        flow_irq_o,
  input wire logic        inverted_flow_output_o
);
  // ********
  // properties
  // ********
  // one clock domain; reset aborts every attempt
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // lamps mirror the state
  a_lamp_state: assert property (active_lamp_o == (state_o == 2'b01))
    else $error("active lamp wrong");
  a_error_lamp: assert property (error_lamp_o == (state_o == 2'b11))
    else $error("error lamp wrong");
  // drive and setpoint held off outside active
  a_drive_gate: assert property (
    state_o != 2'b01 |-> !motor_enable_o && speed_setpoint_o == 12'h000)
    else $error("drive outside active");
  // a held fault latches the error state
  a_fault_stop: assert property (
    $rose(fault_i || overcurrent_i) ##1 (fault_i || overcurrent_i)[*4] |-> state_o == 2'b11)
    else $error("fault not latched");
  a_error_held: assert property (
    (state_o == 2'b11 && !error_clear_switch_i)[*6] |=> state_o == 2'b11)
    else $error("error left early");
  // flow line mirror and edge events
  a_flow_mirror: assert property (
    $stable(flow_edge_interrupt_i)[*5] |-> inverted_flow_output_o != flow_edge_interrupt_i)
    else $error("flow mirror wrong");
  a_flow_event: assert property (
    $changed(flow_edge_interrupt_i) |-> ##[1:5] flow_irq_o)
    else $error("flow edge missed");
  a_tick_period: assert property (
    sample_tick_o |-> ##[TICK_CYC:TICK_CYC] sample_tick_o)
    else $error("tick period wrong");
endmodule
bind mcm_ctrl mcm_ctrl_checker #(.TICK_CYC(TICK_CYC)) u_chk (.*);

// ### sim/mcm_pc_model.sv
/* pc end of the serial link: selects, clocks one 16-bit word, owns flow.
   assumes the block shifts msb first and changes data on falling sclk. */
`timescale 1ns/1ps
module mcm_pc_model (
  input  wire logic pc_miso_i,
  input  wire logic pc_miso_oen_i,
  output logic      pc_sclk_o,
  output logic      pc_csn_o,
  output logic      flow_o
);
  logic last_q;
  logic line;
  // a released data line shows the inverse of the last bit taken
  assign line = pc_miso_oen_i ? ~last_q : pc_miso_i;
  // clock rests low outside frames; flow low lets data run
  initial begin
    pc_sclk_o = 1'b0;
    pc_csn_o = 1'b1;
    flow_o = 1'b0;
    last_q = 1'b0;
  end
  // one select frame at 48 ns, bit taken on each rising edge
  task automatic read_word(output logic [15:0] w);
    w = '0;
    pc_csn_o = 1'b0;
    #48;
    repeat (16) begin
      pc_sclk_o = 1'b1;
      w = {w[14:0], line};
      last_q = line;
      #24;
      pc_sclk_o = 1'b0;
      #24;
    end
    pc_csn_o = 1'b1;
    #48;
  endtask
endmodule

// ### sim/test_motor_current_monitor_ctrl.sv
/* bench for the motor current monitor control block.
   assumes the pc model on the serial pins and a 20-cycle tick. */
`timescale 1ns/1ps
module test_motor_current_monitor_ctrl;
  logic        clk, rstn, run, clr, oc, flt, sv, slast, cv, sclk, csn, flow;
  logic        men, alamp, elamp, tick, frdy, fv, flast, irq, inv, miso, oen;
  logic [1:0]  st;
  logic [8:0]  fbase;
  logic [7:0]  fbin;
  logic [11:0] pot, adc, setp;
  logic [15:0] smag, cpn, cpa, fdb, abn, w;
  int          num_errors, num_checks;
  mcm_ctrl #(.TICK_CYC(20)) DUT (
    .mclk_i(clk), .rstn_i(rstn), .run_switch_i(run), .error_clear_switch_i(clr),
    .overcurrent_i(oc), .fault_i(flt), .speed_potentiometer_i(pot),
    .current_converter_i(adc), .spec_valid_i(sv), .spec_mag_i(smag), .spec_last_i(slast),
    .cls_valid_i(cv), .cls_prob_normal_i(cpn), .cls_prob_abnormal_i(cpa),
    .flow_edge_interrupt_i(flow), .pc_sclk_i(sclk), .pc_csn_i(csn), .state_o(st),
    .motor_enable_o(men), .active_lamp_o(alamp), .error_lamp_o(elamp),
    .speed_setpoint_o(setp), .sample_tick_o(tick), .frame_ready_o(frdy),
    .frame_base_o(fbase), .feat_valid_o(fv), .feat_bin_o(fbin), .feat_db_o(fdb),
    .feat_last_o(flast), .abnormality_o(abn), .flow_irq_o(irq),
    .inverted_flow_output_o(inv), .pc_miso_o(miso), .pc_miso_oen_o(oen));
  mcm_pc_model pc (
    .pc_miso_i(miso), .pc_miso_oen_i(oen), .pc_sclk_o(sclk), .pc_csn_o(csn), .flow_o(flow));
  // ********
  // helpers
  // ********
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #300000;
    num_errors++;
    $display("watchdog expired");
    wrap_up();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (int k = 0; k < 20 && st !== s; k++) cyc(1);
  endtask
  task automatic clr_pulse;
    @(posedge clk);
    clr <= 1'b1;
    cyc(4);
    @(posedge clk);
    clr <= 1'b0;
    cyc(6);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_start;
    check("reset outputs", 16'({st, alamp, elamp, men, inv, oen}), 16'h0003);
    @(posedge clk);
    run <= 1'b1;
    wait_st(2'b01);
    check("lamp and drive", 16'({st, alamp, men}), 16'h0007);
    check("setpoint", 16'(setp), 16'(pot));
    $display("start test done");
  endtask
  task automatic t_frame;
    int n;
    for (int f = 0; f < 2; f++) begin
      n = 0;
      for (int k = 0; k < 12000 && frdy !== 1'b1; k++) begin
        cyc(1);
        n += int'(tick === 1'b1);
      end
      if (f == 0) check("first frame", 16'(n >= 511 && n <= 512), 16'h0001);
      else check("ticks per frame", 16'(n), 16'd448);
      check("frame base", 16'(fbase), f ? 16'h01c0 : 16'h0000);
      cyc(1);
    end
    pc.read_word(w);
    check("serial word", w, {4'h1, adc});
    $display("frame test done");
  endtask
  task automatic t_spec(input int peak);
    int lo;
    int hi;
    int n;
    lo = peak < 8 ? 0 : peak - 8;
    hi = peak > 247 ? 255 : peak + 8;
    n = 0;
    for (int b = 0; b < 257; b++) begin
      @(posedge clk);
      sv <= b < 256;
      smag <= b == 0 ? 16'hffff : (b == peak ? 16'h0fff : 16'h0001);
      slast <= b == 255;
    end
    repeat (40) begin
      cyc(1);
      if (fv === 1'b1) begin
        if (n == 0) check("first bin", 16'(fbin), 16'(lo));
        if (fbin == peak) check("peak level", fdb, 16'h0000);
        if (n == hi - lo) check("last mark", 16'({flast, fbin}), 16'(256 + hi));
        n++;
      end
    end
    check("feature bins", 16'(n), 16'(hi - lo + 1));
    @(posedge clk);
    cv <= 1'b1;
    cpa <= 16'h7a5c;
    @(posedge clk);
    cv <= 1'b0;
    cyc(3);
    check("abnormality", abn, 16'h7a5c);
    $display("spectrum test done");
  endtask
  task automatic t_flow;
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      pc.flow_o <= v[0];
      for (int k = 0; k < 10 && irq !== 1'b1; k++) cyc(1);
      check("flow event", 16'(irq), 16'h0001);
      cyc(3);
      check("inverted flow", 16'(inv), 16'(!v[0]));
    end
    $display("flow test done");
  endtask
  task automatic t_error(input bit use_oc, input logic [1:0] back);
    @(posedge clk);
    if (use_oc) oc <= 1'b1;
    else flt <= 1'b1;
    wait_st(2'b11);
    check("error entry", 16'({st, elamp, men}), 16'h000e);
    clr_pulse();
    check("clear under fault", 16'(st), 16'h0003);
    @(posedge clk);
    {oc, flt} <= 2'b00;
    cyc(10);
    check("error latched", 16'({st, men}), 16'h0006);
    clr_pulse();
    wait_st(back);
    check("error cleared", 16'(st), 16'(back));
    $display("error test done");
  endtask
  // a mid-run reset clears a latched error
  task automatic t_reset;
    @(posedge clk);
    flt <= 1'b1;
    wait_st(2'b11);
    @(posedge clk);
    {rstn, flt} <= 2'b00;
    cyc(4);
    @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    check("reset leaves error", 16'({st, elamp, men, oen}), 16'h0001);
    $display("reset test done");
  endtask
  // main sequence
  initial begin
    {rstn, run, clr, oc, flt, sv, slast, cv} = '0;
    {smag, cpa} = '0;
    cpn = 16'h1234;
    pot = 12'h8c8;
    adc = 12'h5a3;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    cyc(1);
    t_start();
    t_frame();
    t_spec(100);
    t_spec(250);
    t_flow();
    t_error(1'b0, 2'b01);
    @(posedge clk);
    run <= 1'b0;
    wait_st(2'b00);
    t_error(1'b1, 2'b00);
    t_reset();
    wrap_up();
  end
endmodule
